// File: shared/ise_pkg.sv
package ise_pkg;

  // Instruction word and data widths.
  localparam int INSN_W = 12;
  localparam int DATA_W = 8;
  localparam int FADR_W = 5;

  // Opcode patterns, matched against the instruction word under a mask.
  localparam logic [11:0] OP_HALT      = 12'h003;
  localparam logic [11:0] MASK_FULL    = 12'hfff;
  localparam logic [11:0] OP_SUB       = 12'h080;
  localparam logic [11:0] OP_SWAP      = 12'h380;
  localparam logic [11:0] OP_XORF      = 12'h180;
  localparam logic [11:0] MASK_FD      = 12'hfc0;
  localparam logic [11:0] OP_DIRLOAD   = 12'h000;
  localparam logic [11:0] MASK_DIR     = 12'hff8;
  localparam logic [11:0] OP_XORL      = 12'hf00;
  localparam logic [11:0] MASK_LIT     = 12'hf00;

  // Field positions inside the instruction word.
  localparam int DEST_BIT  = 5;
  localparam int FADR_LSB  = 0;
  localparam int LIT_LSB   = 0;
  localparam int DSEL_LSB  = 0;

  // The only direction register select that the core accepts.
  localparam logic [2:0] DIR_SEL_VALID = 3'h6;

  // Reset values.
  localparam logic [7:0] ACC_RST     = 8'h00;
  localparam logic [7:0] DIR_RST     = 8'hff;
  localparam logic [7:0] WDOG_CLEAR  = 8'h00;
  localparam logic       TIMEOUT_RST = 1'b1;
  localparam logic       PDOWN_RST   = 1'b1;

  // Execution state of the core.
  typedef enum logic [1:0] {
    ISE_RUN  = 2'b01,
    ISE_HALT = 2'b10
  } ise_state_type;

endpackage

// File: verilog/ise_flag_reg.sv
`timescale 1ns/1ps

// One status flag with a synchronous load and an asynchronous reset.
module ise_flag_reg #(
  parameter logic RST_VAL = 1'b0
) (
  input  wire logic clk_i,
  input  wire logic sys_rst_i,
  input  wire logic load_i,
  input  wire logic value_i,
  output logic      flag_o
);

  // The flag only moves when its instruction asks for it.
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      flag_o <= RST_VAL;
    end else if (load_i) begin
      flag_o <= value_i;
    end
  end

endmodule

// File: verilog/ise_exec.sv
`timescale 1ns/1ps

module ise_exec (
  input  wire logic                    clk_i,
  input  wire logic                    sys_rst_i,
  input  wire logic                    insn_valid_i,
  input  wire logic [ise_pkg::INSN_W-1:0] insn_i,
  input  wire logic [ise_pkg::DATA_W-1:0] file_rdata_i,
  input  wire logic                    carry_i,
  input  wire logic                    digit_carry_i,
  input  wire logic                    zero_i,
  input  wire logic                    wake_i,
  output logic [ise_pkg::FADR_W-1:0]   file_addr_o,
  output logic [ise_pkg::DATA_W-1:0]   file_wdata_o,
  output logic                         file_we_o,
  output logic [ise_pkg::DATA_W-1:0]   acc_o,
  output logic                         carry_o,
  output logic                         digit_carry_flag_o,
  output logic                         zero_o,
  output logic                         status_we_o,
  output logic                         timeout_flag_o,
  output logic                         power_down_flag_o,
  output logic [ise_pkg::DATA_W-1:0]   pin_direction_o,
  output logic                         watchdog_clear_o,
  output logic [ise_pkg::DATA_W-1:0]   watchdog_counter_o,
  output logic                         osc_stop_o,
  output logic                         halted_o
);
  import ise_pkg::*;

  // Execution state. The codes are one-hot, so a single flop tells run
  // from halt and a corrupted code is easy to spot.
  ise_state_type state;
  ise_state_type next_state;

  // Opcode decode. Each pattern is compared under its own mask, and
  // every strobe carries the run qualifier, so a word that arrives
  // while the core is halted changes only the file address and data. The direction
  // load mask also matches the halt word; the select check below keeps
  // that overlap harmless.
  wire logic run       = (state == ISE_RUN) && insn_valid_i;
  wire logic is_halt   = run && ((insn_i & MASK_FULL) == OP_HALT);
  wire logic is_sub    = run && ((insn_i & MASK_FD) == OP_SUB);
  wire logic is_swap   = run && ((insn_i & MASK_FD) == OP_SWAP);
  wire logic is_xorf   = run && ((insn_i & MASK_FD) == OP_XORF);
  wire logic is_xorl   = run && ((insn_i & MASK_LIT) == OP_XORL);
  wire logic is_dir    = run && ((insn_i & MASK_DIR) == OP_DIRLOAD);
  wire logic [2:0] dir_sel = insn_i[DSEL_LSB +: 3];
  // Other select values are quietly ignored, like a no-operation; a
  // select that names no register must not disturb the pins.
  wire logic dir_ok    = is_dir && (dir_sel == DIR_SEL_VALID);
  wire logic dest_file = insn_i[DEST_BIT];
  wire logic [DATA_W-1:0] lit = insn_i[LIT_LSB +: DATA_W];

  // The subtraction is done as f + ~W + 1, so the carry out is the
  // inverted borrow and the nibble carry is the inverted nibble borrow.
  // Both sums are one bit wider than their operands so that the carry
  // out is never lost to truncation, and the nibble sum is kept apart
  // rather than sliced from the byte sum, whose bit 4 is a sum bit.
  wire logic [DATA_W:0] sub_sum =
    {1'b0, file_rdata_i} + {1'b0, ~acc_o} + 9'h001;
  wire logic [4:0] sub_low =
    {1'b0, file_rdata_i[3:0]} + {1'b0, ~acc_o[3:0]} + 5'h01;
  wire logic sub_carry = sub_sum[DATA_W];
  wire logic sub_dc    = sub_low[4];

  // Plain results. The swap is only wiring; the two exclusive-OR forms
  // share nothing, because one takes the file and the other the literal.
  wire logic [DATA_W-1:0] swap_res =
    {file_rdata_i[3:0], file_rdata_i[7:4]};
  wire logic [DATA_W-1:0] xorf_res = acc_o ^ file_rdata_i;
  wire logic [DATA_W-1:0] xorl_res = acc_o ^ lit;

  // Result selection for the file-register group. The same result feeds
  // both the working register and the file write port, and the
  // destination bit only picks which of the two is told to load it.
  wire logic fd_op = is_sub || is_swap || is_xorf;
  wire logic [DATA_W-1:0] fd_res =
    is_sub  ? sub_sum[DATA_W-1:0] :
    is_swap ? swap_res : xorf_res;
  wire logic [DATA_W-1:0] next_acc =
    is_xorl ? xorl_res : fd_res;
  wire logic acc_load = is_xorl || (fd_op && !dest_file);
  wire logic file_load = fd_op && dest_file;

  // Flag updates. Swap and direction load touch no flag; for them the
  // flag outputs simply repeat the inputs, so a status register that
  // ignored the write pulse would still see no change. Zero is judged
  // on the result itself, so it is right for either destination.
  wire logic zero_load  = is_sub || is_xorf || is_xorl;
  wire logic next_zero  = (next_acc == 8'h00);
  wire logic next_carry = is_sub ? sub_carry : carry_i;
  wire logic next_dc    = is_sub ? sub_dc : digit_carry_i;
  wire logic next_z     = zero_load ? next_zero : zero_i;

  // Next state. Halt is left only when the wake input is raised; the
  // wake sources themselves belong to the logic outside this block.
  // An illegal code falls back to run rather than locking the core.
  always_comb begin
    next_state = state;
    case (state)
      ISE_RUN: begin
        if (is_halt) begin
          next_state = ISE_HALT;
        end
      end
      ISE_HALT: begin
        if (wake_i) begin
          next_state = ISE_RUN;
        end
      end
      default: begin
        next_state = ISE_RUN;
      end
    endcase
  end

  // State register. The asynchronous reset puts the core back in run
  // with no instruction pending.
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      state <= ISE_RUN;
    end else begin
      state <= next_state;
    end
  end

  // One named wire for the halt level, shared by both halt outputs, so
  // the two can never disagree by a cycle.
  wire logic enter_halt = (next_state == ISE_HALT);

  // Oscillator stop, raised on the edge that takes the halt word. It is
  // kept apart from the halted level so that the clock gate outside can
  // be retimed without touching the decoder.
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      osc_stop_o <= 1'b0;
    end else begin
      osc_stop_o <= enter_halt;
    end
  end

  // Halted level for the fetch path. While it stands, every word on the
  // instruction port is ignored, which is what keeps the halt to one
  // word and one cycle however long the fetch path keeps offering words.
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      halted_o <= 1'b0;
    end else begin
      halted_o <= enter_halt;
    end
  end

  // Working register. It moves only for a word that names it as the
  // destination, so the direction load below always copies the value
  // that the previous instruction left behind.
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      acc_o <= ACC_RST;
    end else if (acc_load) begin
      acc_o <= next_acc;
    end
  end

  // Pin direction register. A refused select keeps the old directions,
  // since guessing at another port could turn an input into a driver
  // and fight whatever the board has connected to that pin.
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      pin_direction_o <= DIR_RST;
    end else if (dir_ok) begin
      pin_direction_o <= acc_o;
    end
  end

  // File write address and data. They follow every word, taken or not;
  // only the write enable below says whether the file may use them, so
  // the file must never write on address and data alone.
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      file_addr_o  <= '0;
      file_wdata_o <= '0;
    end else begin
      file_addr_o  <= insn_i[FADR_LSB +: FADR_W];
      file_wdata_o <= fd_res;
    end
  end

  // File write enable, a one-cycle pulse for a file destination.
  // It is the only qualifier of the address and data above.
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      file_we_o <= 1'b0;
    end else begin
      file_we_o <= file_load;
    end
  end

  // Carry out. Outside a subtraction it repeats the carry input, so the
  // status register may take the whole group without losing a bit.
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      carry_o <= 1'b0;
    end else begin
      carry_o <= next_carry;
    end
  end

  // Digit carry out, the inverted borrow out of the low nibble.
  // Like the carry, it repeats its input for every other word.
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      digit_carry_flag_o <= 1'b0;
    end else begin
      digit_carry_flag_o <= next_dc;
    end
  end

  // Zero out, judged on the result whichever destination it goes to.
  // A file destination still reports zero, as software expects.
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      zero_o <= 1'b0;
    end else begin
      zero_o <= next_z;
    end
  end

  // Status write pulse. Swap and direction load leave it low, so the
  // status register keeps its flags even if the inputs above drift.
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      status_we_o <= 1'b0;
    end else begin
      status_we_o <= zero_load;
    end
  end

  // Watchdog prescaler clear, a one-cycle pulse to the timer outside.
  // A longer pulse would hold the prescaler and lose timer ticks.
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      watchdog_clear_o <= 1'b0;
    end else begin
      watchdog_clear_o <= is_halt;
    end
  end

  // Watchdog counter value seen by software. The counting itself lives
  // in the timer outside; this copy only has to show zero after a halt,
  // which is a known limitation of keeping the timer out of this block.
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      watchdog_counter_o <= WDOG_CLEAR;
    end else if (is_halt) begin
      watchdog_counter_o <= WDOG_CLEAR;
    end
  end

  // Halt sets timeout and clears power-down through two copies of the
  // same small flag cell. The wake flag is not an output here, so it
  // cannot be disturbed; the wake logic outside keeps it as it was.
  ise_flag_reg #(.RST_VAL(TIMEOUT_RST)) u_timeout (
    .clk_i    (clk_i),
    .sys_rst_i(sys_rst_i),
    .load_i   (is_halt),
    .value_i  (1'b1),
    .flag_o   (timeout_flag_o)
  );

  // Power-down flag; reset high, cleared by every halt.
  ise_flag_reg #(.RST_VAL(PDOWN_RST)) u_pdown (
    .clk_i    (clk_i),
    .sys_rst_i(sys_rst_i),
    .load_i   (is_halt),
    .value_i  (1'b0),
    .flag_o   (power_down_flag_o)
  );

endmodule

// File: dv/ise_checker.sv
`timescale 1ns/1ps

// Ties each result to the instruction taken one edge before it.
module ise_checker
  import ise_pkg::*;
(
  input wire logic        clk_i,
  input wire logic        sys_rst_i,
  input wire logic        insn_valid_i,
  input wire logic [11:0] insn_i,
  input wire logic [7:0]  file_rdata_i,
  input wire logic [7:0]  acc_o,
  input wire logic        carry_o,
  input wire logic        zero_o,
  input wire logic        status_we_o,
  input wire logic        file_we_o,
  input wire logic [7:0]  file_wdata_o,
  input wire logic        timeout_flag_o,
  input wire logic        power_down_flag_o,
  input wire logic [7:0]  pin_direction_o,
  input wire logic        watchdog_clear_o,
  input wire logic [7:0]  watchdog_counter_o,
  input wire logic        osc_stop_o,
  input wire logic        halted_o
);
  // A word only counts while the core runs, so halted words are ignored.
  wire logic       tk   = insn_valid_i && !halted_o;
  wire logic       hlt  = tk && insn_i == OP_HALT;
  wire logic       sub  = tk && (insn_i & MASK_FD) == OP_SUB;
  wire logic       swp  = tk && (insn_i & MASK_FD) == OP_SWAP;
  wire logic       xf   = tk && (insn_i & MASK_FD) == OP_XORF;
  wire logic       xl   = tk && (insn_i & MASK_LIT) == OP_XORL;
  wire logic       dbit = insn_i[DEST_BIT];
  wire logic [7:0] lit  = insn_i[7:0];

  default clocking @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);

  halt_stop_a: assert property (
    hlt |=> osc_stop_o && halted_o)
    else $error("halt did not stop the core");
  halt_status_a: assert property (
    hlt |=> timeout_flag_o && !power_down_flag_o)
    else $error("halt status bits wrong");
  wdog_clear_a: assert property (
    hlt |=> watchdog_clear_o && watchdog_counter_o == WDOG_CLEAR)
    else $error("watchdog not cleared");
  sub_diff_a: assert property (
    sub && dbit |=>
      file_wdata_o == $past(file_rdata_i) - $past(acc_o))
    else $error("difference wrong");
  sub_carry_a: assert property (
    sub |=> carry_o == ($past(file_rdata_i) >= $past(acc_o)))
    else $error("borrow sense wrong");
  dest_sel_a: assert property (
    sub || swp || xf |=> file_we_o == $past(dbit))
    else $error("destination wrong");
  swap_quiet_a: assert property (
    swp |=> !status_we_o)
    else $error("swap wrote status");
  dir_load_a: assert property (
    tk && insn_i == 12'h006 |=> pin_direction_o == $past(acc_o))
    else $error("direction load wrong");
  xorl_acc_a: assert property (
    xl |=> acc_o == ($past(acc_o) ^ $past(lit))
      && zero_o == (acc_o == 8'h00))
    else $error("literal xor wrong");
  xorf_zero_a: assert property (
    xf |=> status_we_o
      && zero_o == ($past(acc_o) == $past(file_rdata_i)))
    else $error("file xor zero wrong");

  cover property (hlt);
  cover property (sub && dbit);
  cover property (xf);
  cover property (swp);
endmodule

bind ise_exec ise_checker ise_checker_i (.clk_i, .sys_rst_i, .insn_valid_i,
  .insn_i, .file_rdata_i, .acc_o, .carry_o, .zero_o, .status_we_o, .file_we_o,
  .file_wdata_o, .timeout_flag_o, .power_down_flag_o, .pin_direction_o,
  .watchdog_clear_o, .watchdog_counter_o, .osc_stop_o, .halted_o);

// File: dv/tb_ise_exec.sv
`timescale 1ns/1ps

module tb_ise_exec;
  import ise_pkg::*;
  logic        clk_i = 1'b0, sys_rst_i = 1'b1, insn_valid_i = 1'b0;
  logic [11:0] insn_i = 12'h000;
  logic [7:0]  file_rdata_i = 8'h00;
  logic        carry_i = 1'b0, digit_carry_i = 1'b0, zero_i = 1'b0;
  logic        wake_i = 1'b0;
  logic [4:0]  file_addr_o;
  logic [7:0]  file_wdata_o, acc_o, pin_direction_o, watchdog_counter_o;
  logic        file_we_o, carry_o, digit_carry_flag_o, zero_o, status_we_o;
  logic        timeout_flag_o, power_down_flag_o, watchdog_clear_o;
  logic        osc_stop_o, halted_o;
  int          num_errors = 0, checks_done = 0, cycles = 0;
  // Flags packed as C, DC, Z, status write, file write.
  wire logic [7:0] fl = {3'h0, carry_o, digit_carry_flag_o, zero_o,
                         status_we_o, file_we_o};

  ise_exec ise_exec_i (.clk_i, .sys_rst_i, .insn_valid_i, .insn_i,
    .file_rdata_i, .carry_i, .digit_carry_i, .zero_i, .wake_i, .file_addr_o,
    .file_wdata_o, .file_we_o, .acc_o, .carry_o, .digit_carry_flag_o, .zero_o,
    .status_we_o, .timeout_flag_o, .power_down_flag_o, .pin_direction_o,
    .watchdog_clear_o, .watchdog_counter_o, .osc_stop_o, .halted_o);

  // The clock at 8 ns; the limit sits far above the 54 or so cycles used.
  always #4 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      num_errors = num_errors + 1;
      end_of_test();
    end
  end

  task automatic chk(input string what, input logic [7:0] got, exp);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  // One word; results are read just after the edge that takes it.
  task automatic run(input logic [11:0] w, input logic [7:0] f);
    @(posedge clk_i);
    insn_valid_i <= 1'b1;
    insn_i <= w;
    file_rdata_i <= f;
    @(posedge clk_i);
    insn_valid_i <= 1'b0;
    #1;
  endtask

  task automatic t_xorl();
    logic [7:0] k[4] = '{8'hb5, 8'haf, 8'h1a, 8'h02};
    logic [7:0] w[4] = '{8'hb5, 8'h1a, 8'h00, 8'h02};
    logic [7:0] f[4] = '{8'h02, 8'h02, 8'h06, 8'h02};
    for (int i = 0; i < 4; i++) begin
      run({4'hf, k[i]}, 8'h00);
      chk("xorl acc", acc_o, w[i]);
      chk("xorl flags", fl, f[i]);
    end
    $display("xorl done");
  endtask

  // W is 02: positive, zero and negative results, both destinations.
  task automatic t_sub();
    run(12'h0a5, 8'h03);
    chk("sub data", file_wdata_o, 8'h01);
    chk("sub flags", fl, 8'h1b);
    chk("sub addr", {3'h0, file_addr_o}, 8'h05);
    run(12'h0a5, 8'h02);
    chk("sub zero", fl, 8'h1f);
    run(12'h085, 8'h01);
    chk("sub acc", acc_o, 8'hff);
    chk("sub borrow", fl, 8'h02);
    $display("sub done");
  endtask

  task automatic t_xorf_swap();
    run(12'h1a3, 8'hff);
    chk("xorf data", file_wdata_o, 8'h00);
    chk("xorf flags", fl, 8'h07);
    run(12'h183, 8'h5a);
    chk("xorf acc", acc_o, 8'ha5);
    run(12'h3a4, 8'h3c);
    chk("swap data", file_wdata_o, 8'hc3);
    chk("swap flags", fl, 8'h01);
    run(12'h384, 8'ha5);
    chk("swap acc", acc_o, 8'h5a);
    $display("xorf swap done");
  endtask

  // Select 5 must be refused before select 6 loads W.
  task automatic t_dir_halt();
    run(12'h005, 8'h00);
    chk("dir bad", pin_direction_o, 8'hff);
    run(12'h006, 8'h00);
    chk("dir load", pin_direction_o, 8'h5a);
    run(OP_HALT, 8'h00);
    chk("halt", {3'h0, osc_stop_o, halted_o, timeout_flag_o,
        power_down_flag_o, watchdog_clear_o}, 8'h1d);
    chk("wdog", watchdog_counter_o, 8'h00);
    run(12'hf0f, 8'h00);
    chk("halt acc", acc_o, 8'h5a);
    @(posedge clk_i);
    wake_i <= 1'b1;
    @(posedge clk_i);
    wake_i <= 1'b0;
    #1;
    chk("woke", {7'h00, halted_o}, 8'h00);
    run(12'hf0f, 8'h00);
    chk("woke acc", acc_o, 8'h55);
    $display("dir halt done");
  endtask

  task automatic end_of_test();
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  initial begin
    repeat (20) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    #1;
    chk("rst acc", acc_o, ACC_RST);
    chk("rst dir", pin_direction_o, DIR_RST);
    t_xorl();
    t_sub();
    t_xorf_swap();
    t_dir_halt();
    end_of_test();
  end
endmodule
